// file: mmdec_pkg.sv
// mmdec_pkg: constants and types for the memory map address decoder
package mmdec_pkg;
  // address space
  localparam int ADDR_W = 20;
  localparam logic [19:0] DATA_LO_BASE = 20'h0d600; // data area base, low placement
  localparam logic [19:0] DATA_HI_BASE = 20'hfd600; // data area base, upper placement
  localparam logic [19:0] BASE_TOP = 20'h0ffff; // last byte of the base area
  localparam logic [19:0] ROM_TOP = 20'h3ffff; // last byte of internal rom
  localparam logic [15:0] NOFETCH_LO = 16'hfd00; // high-speed ram and sfr start here
  localparam logic [15:0] DATA_OFS_BASE = 16'hd600; // low 16 bits of data area base
  // vector and table call areas
  localparam logic [19:0] VEC_BASE = 20'h00000; // vector table, 64 bytes
  localparam logic [19:0] TCALL_BASE = 20'h00040; // call table, 32 entries
  // fetch timing in system clocks
  localparam logic [3:0] FAST_CYC = 4'h2; // 2-byte fetch in 2 clocks
  localparam logic [3:0] SLOW_BASE_CYC = 4'h3; // external-equivalent cycle before waits
  localparam logic [3:0] ERR_CYC = 4'h1; // refused access answers at once
  // reset values
  localparam logic HSF_RST = 1'b0; // high-speed fetch off after reset
  localparam logic LOC_UPPER_RST = 1'b0; // decode as low placement until chosen
  // access states
  typedef enum logic {MMDEC_IDLE, MMDEC_BUSY} mmdec_state_type;
endpackage : mmdec_pkg

// file: mmdec_decoder.sv
// mmdec_decoder: address decode, placement latch and fetch timing
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - upper placement: data area FD600H-FFFFFH
// - low placement: data area 0D600H-0FFFFH
// - overlap of rom and data goes data
// - low placement keeps data inside base area
// - base area is 00000H through 0FFFFH
// - external access only in expansion mode
// - high-speed fetch: two clocks per fetch
// - waits only in external-equivalent fetch timing
// - reset clears high-speed fetch
// - no fetch from high-speed ram or sfr
// - vector table occupies 00000H-0003FH
// - vector entries 16 bit, upper bits zero
// - vectors read from fixed two-byte slots
// - table call reads 00040H-0007FH, 32 entries
// - vector and call tables freely readable, writable
// - shadowed rom usable only under upper placement
// - placement accepted once after reset
module mmdec_decoder
  import mmdec_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // placement selection strobe
  input wire logic LOC_SET_I,
  input wire logic LOC_UPPER_I,
  // mode controls
  input wire logic HSF_WR_I,
  input wire logic HSF_VAL_I,
  input wire logic MEM_EXP_I,
  input wire logic [1:0] WAIT_CNT_I,
  // cpu access request
  input wire logic REQ_VALID_I,
  input wire logic [19:0] REQ_ADDR_I,
  input wire logic REQ_FETCH_I,
  input wire logic REQ_WRITE_I,
  input wire logic VEC_REQ_I,
  input wire logic [4:0] VEC_SEL_I,
  input wire logic TCALL_REQ_I,
  input wire logic [4:0] TCALL_SEL_I,
  input wire logic [15:0] RD_DATA_I,
  // memory side selects
  output logic SEL_ROM_O,
  output logic SEL_DATA_O,
  output logic SEL_EXT_O,
  output logic WR_O,
  output logic [19:0] MEM_ADDR_O,
  // answers to the cpu
  output logic BUSY_O,
  output logic DONE_O,
  output logic FETCH_ERR_O,
  output logic EXT_ERR_O,
  output logic BR_VALID_O,
  output logic [19:0] BR_TARGET_O,
  // status
  output logic HSF_O,
  output logic LOC_DONE_O,
  output logic LOC_UPPER_O
);

  mmdec_state_type state_r; // access sequencer
  logic loc_done_r; // placement already chosen
  logic loc_upper_r; // chosen placement
  logic hsf_r; // high-speed fetch select
  logic [3:0] cnt_r; // cycles left in the access
  logic br_pend_r; // access reads a branch target
  logic fetch_err_r; // refused fetch pending
  logic ext_err_r; // refused external access pending

  // request arbitration: vector first, then table call, then plain access
  wire logic idle = (state_r == MMDEC_IDLE);
  wire logic any_req = VEC_REQ_I | TCALL_REQ_I | REQ_VALID_I;
  wire logic accept = idle & any_req;
  wire logic is_vec = VEC_REQ_I;
  wire logic is_tcall = ~VEC_REQ_I & TCALL_REQ_I;
  wire logic is_plain = ~VEC_REQ_I & ~TCALL_REQ_I;
  // fixed two-byte slots, index times two
  wire logic [19:0] vec_addr = VEC_BASE | {14'h0000, VEC_SEL_I, 1'b0};
  wire logic [19:0] tcall_addr = TCALL_BASE | {14'h0000, TCALL_SEL_I, 1'b0};
  wire logic [19:0] acc_addr = is_vec ? vec_addr : (is_tcall ? tcall_addr : REQ_ADDR_I);
  wire logic acc_fetch = is_plain & REQ_FETCH_I;
  // table reads are never writes; plain accesses there pass unprotected
  wire logic acc_write = is_plain & REQ_WRITE_I;

  // region decode; the data area wins any overlap with rom
  wire logic in_base = (acc_addr <= BASE_TOP);
  wire logic in_data_lo = in_base & (acc_addr >= DATA_LO_BASE);
  wire logic in_data_hi = (acc_addr >= DATA_HI_BASE);
  wire logic in_data = loc_upper_r ? in_data_hi : in_data_lo;
  // shadowed rom below 10000H reappears only under the upper placement
  wire logic in_rom = ~in_data & (acc_addr <= ROM_TOP);
  wire logic in_ext = ~in_data & ~in_rom;
  // high-speed ram and sfr hold no code
  wire logic no_fetch = in_data & (acc_addr[15:0] >= NOFETCH_LO);
  wire logic fetch_bad = acc_fetch & no_fetch;
  wire logic ext_bad = in_ext & ~MEM_EXP_I;
  wire logic acc_bad = fetch_bad | ext_bad;
  // offset of the access inside the data area, same for both placements
  wire logic [15:0] data_ofs = acc_addr[15:0] - DATA_OFS_BASE;
  wire logic [19:0] route_addr = in_data ? {4'h0, data_ofs} : acc_addr;

  // access length: fast rom has no waits, slow rom and external take them
  wire logic [3:0] slow_cyc = SLOW_BASE_CYC + {2'b00, WAIT_CNT_I};
  wire logic [3:0] rom_cyc = hsf_r ? FAST_CYC : slow_cyc;
  wire logic [3:0] acc_cyc = acc_bad ? ERR_CYC :
                             (in_rom ? rom_cyc : (in_data ? FAST_CYC : slow_cyc));
  wire logic last = (state_r == MMDEC_BUSY) & (cnt_r == 4'h1);

  // placement latch: first strobe after reset wins, later ones are ignored
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      loc_done_r <= 1'b0;
      loc_upper_r <= LOC_UPPER_RST;
    end else if (LOC_SET_I && !loc_done_r) begin
      loc_done_r <= 1'b1;
      loc_upper_r <= LOC_UPPER_I;
    end
  end

  // high-speed fetch select, cleared by reset
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      hsf_r <= HSF_RST;
    end else if (HSF_WR_I) begin
      hsf_r <= HSF_VAL_I;
    end
  end

  // sequencer: one access at a time, held until its last cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= MMDEC_IDLE;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        MMDEC_IDLE: begin
          if (accept) begin
            state_r <= MMDEC_BUSY;
            cnt_r <= acc_cyc;
          end
        end
        MMDEC_BUSY: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            state_r <= MMDEC_IDLE;
          end
        end
        default: begin
          state_r <= MMDEC_IDLE;
        end
      endcase
    end
  end

  // memory selects: raised at accept, dropped on the last cycle
  // a refused access raises no select so nothing reaches a memory
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SEL_ROM_O <= 1'b0;
      SEL_DATA_O <= 1'b0;
      SEL_EXT_O <= 1'b0;
      WR_O <= 1'b0;
      MEM_ADDR_O <= 20'h00000;
    end else if (accept) begin
      SEL_ROM_O <= in_rom & ~acc_bad;
      SEL_DATA_O <= in_data & ~acc_bad;
      SEL_EXT_O <= in_ext & ~acc_bad;
      WR_O <= acc_write & ~acc_bad;
      MEM_ADDR_O <= route_addr;
    end else if (last) begin
      SEL_ROM_O <= 1'b0;
      SEL_DATA_O <= 1'b0;
      SEL_EXT_O <= 1'b0;
      WR_O <= 1'b0;
    end
  end

  // pending answer flags captured at accept
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      br_pend_r <= 1'b0;
      fetch_err_r <= 1'b0;
      ext_err_r <= 1'b0;
    end else if (accept) begin
      br_pend_r <= (is_vec | is_tcall) & ~acc_bad;
      fetch_err_r <= fetch_bad;
      ext_err_r <= ext_bad;
    end
  end

  // answers: one-cycle pulses after the last access cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DONE_O <= 1'b0;
      FETCH_ERR_O <= 1'b0;
      EXT_ERR_O <= 1'b0;
      BR_VALID_O <= 1'b0;
      BR_TARGET_O <= 20'h00000;
    end else begin
      DONE_O <= last;
      FETCH_ERR_O <= last & fetch_err_r;
      EXT_ERR_O <= last & ext_err_r;
      BR_VALID_O <= last & br_pend_r;
      if (last && br_pend_r) begin
        // a 16-bit entry can only land inside the base area
        BR_TARGET_O <= {4'h0, RD_DATA_I};
      end
    end
  end

  // status mirrors, registered so outputs come from flip-flops
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
      HSF_O <= 1'b0;
      LOC_DONE_O <= 1'b0;
      LOC_UPPER_O <= 1'b0;
    end else begin
      BUSY_O <= accept | (~idle & ~last);
      HSF_O <= hsf_r;
      LOC_DONE_O <= loc_done_r;
      LOC_UPPER_O <= loc_upper_r;
    end
  end

  // checks, all in the single clock domain
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_upper_data;
    accept && loc_upper_r && !acc_bad && (acc_addr >= DATA_HI_BASE) |=> SEL_DATA_O && !SEL_ROM_O;
  endproperty
  a_upper_data: assert property (p_upper_data) else $error("upper data area not selected");

  property p_low_data;
    accept && !loc_upper_r && !acc_bad && (acc_addr >= DATA_LO_BASE) && (acc_addr <= BASE_TOP)
      |=> SEL_DATA_O && !SEL_ROM_O;
  endproperty
  a_low_data: assert property (p_low_data) else $error("low data area lost to rom");

  property p_shadow_rom;
    accept && loc_upper_r && (acc_addr >= DATA_LO_BASE) && (acc_addr <= BASE_TOP) |=> SEL_ROM_O;
  endproperty
  a_shadow_rom: assert property (p_shadow_rom) else $error("shadowed rom not reached");

  property p_ext_gate;
    accept && in_ext && !MEM_EXP_I |=> !SEL_EXT_O ##[1:1] (DONE_O && EXT_ERR_O);
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external access without expansion");

  property p_fast_fetch;
    accept && in_rom && acc_fetch && hsf_r |=> SEL_ROM_O ##1 SEL_ROM_O ##1 (DONE_O && !SEL_ROM_O);
  endproperty
  a_fast_fetch: assert property (p_fast_fetch) else $error("fast fetch not two clocks");

  property p_slow_fetch;
    accept && in_rom && acc_fetch && !hsf_r && (WAIT_CNT_I == 2'b01) |=> !DONE_O [*4] ##1 DONE_O;
  endproperty
  a_slow_fetch: assert property (p_slow_fetch) else $error("slow fetch wait count wrong");

  property p_reset_slow;
    $rose(RST_N_I) |-> !hsf_r && !loc_done_r && !loc_upper_r;
  endproperty
  a_reset_slow: assert property (@(posedge CLK_I) p_reset_slow) else $error("reset state wrong");

  property p_no_fetch;
    accept && acc_fetch && in_data && (acc_addr[15:0] >= NOFETCH_LO)
      |=> !SEL_DATA_O ##1 (FETCH_ERR_O && DONE_O);
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch from ram or sfr allowed");

  property p_vec_slot;
    accept && is_vec |=> SEL_ROM_O && (MEM_ADDR_O == {14'h0000, $past(VEC_SEL_I), 1'b0});
  endproperty
  a_vec_slot: assert property (p_vec_slot) else $error("vector slot address wrong");

  property p_tcall_slot;
    accept && is_tcall |=> (MEM_ADDR_O >= TCALL_BASE) && (MEM_ADDR_O <= 20'h0007f);
  endproperty
  a_tcall_slot: assert property (p_tcall_slot) else $error("call table address out of range");

  property p_br_base;
    BR_VALID_O |-> (BR_TARGET_O[19:16] == 4'h0) && (BR_TARGET_O[15:0] == $past(RD_DATA_I));
  endproperty
  a_br_base: assert property (p_br_base) else $error("branch target leaves base area");

  property p_loc_once;
    loc_done_r && LOC_SET_I |=> $stable(loc_upper_r) && loc_done_r;
  endproperty
  a_loc_once: assert property (p_loc_once) else $error("placement changed twice");

  c_upper_set: cover property (LOC_SET_I && LOC_UPPER_I && !loc_done_r);
  c_fast_done: cover property (accept && in_rom && hsf_r ##3 DONE_O);
  c_vec_branch: cover property (accept && is_vec ##[1:8] BR_VALID_O);
  c_ext_ok: cover property (accept && in_ext && MEM_EXP_I);

endmodule : mmdec_decoder

`default_nettype wire

// file: mmdec_mem_model.sv
// mmdec_mem_model: behavioural memory side answering the decoder selects
`timescale 1ns/1ps
`default_nettype none
module mmdec_mem_model (
  // clock and select from the decoder
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic [19:0] addr_i,
  // read data back to the decoder
  output logic [15:0] rd_o
);
  logic [15:0] last_r = 16'h0000; // last word driven while selected
  // a released bus shows the inverse of the last word, so stale data never passes as fresh
  assign rd_o = sel_i ? (addr_i[15:0] ^ 16'ha5c3) : ~last_r;
  // remember the word of the current access
  always_ff @(posedge clk_i) begin
    if (sel_i) begin
      last_r <= rd_o;
    end
  end
endmodule : mmdec_mem_model
`default_nettype wire

// file: mmdec_decoder_tb_top.sv
// mmdec_decoder_tb_top: self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module mmdec_decoder_tb_top
  import mmdec_pkg::*;
;
  // stimulus
  logic clk = 1'b0, rst_n = 1'b0, loc_set = 1'b0, loc_up = 1'b0, hsf_wr = 1'b0, hsf_val = 1'b0;
  logic mem_exp = 1'b0, vreq = 1'b0, treq = 1'b0, pval = 1'b0, fetch = 1'b0, wr = 1'b0;
  logic [1:0] wcnt = 2'h0;
  logic [4:0] vsel = 5'h00, tsel = 5'h00;
  logic [19:0] addr = 20'h00000;
  // observed
  logic [15:0] rd;
  logic s_rom, s_data, s_ext, wr_o, busy, done, ferr, eerr, brv, hsf, ldone, lup;
  logic [19:0] maddr, btgt;
  int error_cnt = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  mmdec_decoder dut (.CLK_I(clk), .RST_N_I(rst_n), .LOC_SET_I(loc_set), .LOC_UPPER_I(loc_up),
    .HSF_WR_I(hsf_wr), .HSF_VAL_I(hsf_val), .MEM_EXP_I(mem_exp), .WAIT_CNT_I(wcnt), .REQ_VALID_I(pval),
    .REQ_ADDR_I(addr), .REQ_FETCH_I(fetch), .REQ_WRITE_I(wr), .VEC_REQ_I(vreq), .VEC_SEL_I(vsel),
    .TCALL_REQ_I(treq), .TCALL_SEL_I(tsel), .RD_DATA_I(rd), .SEL_ROM_O(s_rom), .SEL_DATA_O(s_data),
    .SEL_EXT_O(s_ext), .WR_O(wr_o), .MEM_ADDR_O(maddr), .BUSY_O(busy), .DONE_O(done),
    .FETCH_ERR_O(ferr), .EXT_ERR_O(eerr), .BR_VALID_O(brv), .BR_TARGET_O(btgt), .HSF_O(hsf),
    .LOC_DONE_O(ldone), .LOC_UPPER_O(lup));
  mmdec_mem_model mem (.clk_i(clk), .sel_i(s_rom | s_data | s_ext), .addr_i(maddr), .rd_o(rd));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // one access: kind is {vector, table call, plain}; esel is {rom, data, ext, write}
  task automatic acc(input logic [2:0] kind, input logic [19:0] a, input logic [1:0] wf,
                     input logic [3:0] esel, input logic [19:0] ea, input logic [3:0] en, input logic [1:0] eer);
    logic [3:0] n;
    logic [3:0] sel;
    logic [19:0] ma;
    logic bz;
    @(posedge clk);
    {vreq, treq, pval} <= kind;
    {wr, fetch} <= wf;
    addr <= a;
    vsel <= a[5:1];
    tsel <= a[5:1];
    @(posedge clk);
    {vreq, treq, pval} <= 3'b000;
    n = 4'h0;
    sel = 4'h0;
    ma = 20'h00000;
    bz = 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 4'h1) begin
        sel = {s_rom, s_data, s_ext, wr_o};
        ma = maddr;
        bz = busy;
      end
    end while (done !== 1'b1 && n < 4'hf);
    chk(n, en);
    chk(sel, esel);
    chk(ma, ea);
    chk({ferr, eerr}, eer);
    // busy stands from the edge after the take until done, so a refused access has dropped it again by the first sample
    chk(bz, en != 4'h1);
    chk(busy, 1'b0);
    // branch target carries the 16-bit word with the upper bits zero
    if (kind[2:1] != 2'b00) begin
      chk({brv, btgt}, {1'b1, 4'h0, a[15:0] ^ 16'ha5c3});
    end else begin
      chk(brv, 1'b0);
    end
  endtask : acc
  // strobe placement or high-speed select, then let the status settle
  task automatic pulse(input logic l, input logic h, input logic v);
    @(posedge clk);
    loc_set <= l;
    hsf_wr <= h;
    loc_up <= v;
    hsf_val <= v;
    @(posedge clk);
    loc_set <= 1'b0;
    hsf_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  // default decode before any placement choice
  task automatic t_low();
    @(posedge clk);
    wcnt <= 2'h1;
    acc(3'b001, 20'h0d600, 2'b00, 4'h4, 20'h00000, 4'h2, 2'h0);
    acc(3'b001, 20'h0d5ff, 2'b00, 4'h8, 20'h0d5ff, 4'h4, 2'h0);
    acc(3'b001, 20'h01000, 2'b01, 4'h8, 20'h01000, 4'h4, 2'h0);
    acc(3'b001, 20'h0ffff, 2'b00, 4'h4, 20'h029ff, 4'h2, 2'h0);
    acc(3'b001, 20'h0fcff, 2'b01, 4'h4, 20'h026ff, 4'h2, 2'h0);
    // a refused access still shows its routed address, but no select
    acc(3'b001, 20'h0fd00, 2'b01, 4'h0, 20'h02700, 4'h1, 2'h2);
    acc(3'b001, 20'h0ff00, 2'b01, 4'h0, 20'h02900, 4'h1, 2'h2);
    acc(3'b001, 20'h10000, 2'b00, 4'h8, 20'h10000, 4'h4, 2'h0);
    acc(3'b001, 20'h0007e, 2'b10, 4'h9, 20'h0007e, 4'h4, 2'h0);
    acc(3'b001, 20'h40000, 2'b00, 4'h0, 20'h40000, 4'h1, 2'h1);
    @(posedge clk);
    mem_exp <= 1'b1;
    acc(3'b001, 20'h40000, 2'b00, 4'h2, 20'h40000, 4'h4, 2'h0);
    $display("test low placement done");
  endtask : t_low
  // every vector slot and call table entry
  task automatic t_tables();
    @(posedge clk);
    wcnt <= 2'h0;
    for (int s = 0; s < 32; s++) begin
      acc(3'b100, 20'(2 * s), 2'b00, 4'h8, 20'(2 * s), 4'h3, 2'h0);
      acc(3'b010, 20'(64 + 2 * s), 2'b00, 4'h8, 20'(64 + 2 * s), 4'h3, 2'h0);
    end
    $display("test tables done");
  endtask : t_tables
  // fetch speed with and without the high-speed select
  task automatic t_hsf();
    @(posedge clk);
    wcnt <= 2'h3;
    pulse(1'b0, 1'b1, 1'b1);
    chk(hsf, 1'b1);
    acc(3'b001, 20'h00100, 2'b01, 4'h8, 20'h00100, FAST_CYC, 2'h0);
    pulse(1'b0, 1'b1, 1'b0);
    acc(3'b001, 20'h00100, 2'b01, 4'h8, 20'h00100, 4'h6, 2'h0);
    $display("test fetch speed done");
  endtask : t_hsf
  // upper placement, then an ignored second choice
  task automatic t_place();
    @(posedge clk);
    wcnt <= 2'h0;
    pulse(1'b1, 1'b0, 1'b1);
    chk({ldone, lup}, 2'h3);
    pulse(1'b1, 1'b0, 1'b0);
    chk({ldone, lup}, 2'h3);
    acc(3'b001, 20'h0d600, 2'b00, 4'h8, 20'h0d600, 4'h3, 2'h0);
    acc(3'b001, 20'hfd600, 2'b00, 4'h4, 20'h00000, 4'h2, 2'h0);
    acc(3'b001, 20'hfffff, 2'b00, 4'h4, 20'h029ff, 4'h2, 2'h0);
    acc(3'b001, 20'h3ffff, 2'b01, 4'h8, 20'h3ffff, 4'h3, 2'h0);
    acc(3'b001, 20'hffd00, 2'b01, 4'h0, 20'h02700, 4'h1, 2'h2);
    $display("test upper placement done");
  endtask : t_place
  // watchdog sized well past the expected run of about 450 cycles
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({s_rom, s_data, s_ext, done, hsf, ldone, lup}, 7'h00);
    @(posedge clk);
    #1;
    chk({hsf, ldone, lup}, 3'h0);
    t_low();
    t_tables();
    t_hsf();
    t_place();
    test_done();
  end
endmodule : mmdec_decoder_tb_top
`default_nettype wire
